// ### verilog/rsff_formatter.sv
// Purpose: Turns received replies into ASCII raw frames, one char at a time
// Assumes: Replies arrive with payload left aligned, MSB first
// Notes:   Timestamps come from free counters reset by the pulse edge and by midnight_clear
//          Counters step 100 ns a clock and are left uncalibrated
//          Timestamp fields keep leading zeros, decimal fields drop them
//          The sink may stall any character; nothing is ever dropped
// Summary of operation
// RULE1 - Each frame opens with an asterisk and payload closes with semicolon.
// RULE2 - Payload goes out as ASCII hex, most significant bit first.
// RULE3 - Replies pass unaltered: no decoding, filtering or parity checking.
// RULE4 - Host checks checksums and does all further processing itself.
// RULE5 - Extended fields follow in parentheses, comma separated, then CR LF.
// RULE6 - First extended field is signal strength, signed decimal dBm.
// RULE7 - Second extended field is signal quality, decimal dB.
// RULE8 - Third field is nanoseconds since last pulse edge, in hex.
// RULE9 - Fourth field is nanoseconds since midnight, in hex.
// RULE10 - Timestamps are valid only while an accurate pulse input is driven; timestamp_valid stays set from the first pulse edge on.
// RULE11 - Short replies give 7 payload bytes, long replies 14 bytes.
// RULE12 - Mode-A/C replies give exactly four octal digits, unclassified.
// RULE13 - A/C code bits sit at 14..12, 10..8, 6..4 and 2..0.
// RULE14 - Bits 15, 11, 7 and 3 of the A/C word are zero.
// RULE15 - Host calibrates timestamps with the per-second calibration count. The formatter outputs no calibration count.
`timescale 1ns/1ps
`default_nettype none
`include "rsff_params.svh"

module rsff_formatter #(
  parameter int TS1_DIGITS  = 8,
  parameter int TS24_DIGITS = 12
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 pulse_per_second_input,
  input  wire logic                 midnight_clear,
  input  wire logic                 reply_valid,
  output logic                      reply_ready,
  input  wire rsff_pkg::rsff_reply_t reply,
  output logic [7:0]                char_data,
  output logic                      char_valid,
  input  wire logic                 char_ready,
  output logic                      timestamp_valid
);
  // The field shifter holds at most sixteen digits of a counter
  if (TS1_DIGITS < 8 || TS1_DIGITS > 16 || TS24_DIGITS < 12 ||
      TS24_DIGITS > 16) begin : g_bad_digits
    $error("rsff_formatter: timestamp digit counts out of range");
  end

  localparam logic [63:0] NS_STEP = 64'(`RSFF_NS_PER_CLK);

  rsff_pkg::rsff_state_t state_ff;
  logic [111:0] shift_ff;
  logic [4:0]   count_ff;
  logic [1:0]   field_ff;
  logic [7:0]   dec_ff;
  logic [63:0]  since_pulse_timestamp;
  logic [63:0]  since_midnight_timestamp;
  logic [63:0]  ts1_ff;
  logic [63:0]  ts24_ff;
  logic [7:0]   strength_ff;
  logic [7:0]   quality_ff;
  logic         pulse_prev_ff;
  logic         pulse_seen_ff;
  logic         pulse_edge;
  logic [7:0]   dec_hund;
  logic [7:0]   dec_tens;
  logic [7:0]   dec_unit;
  logic [15:0]  ac_word;
  logic         advance;

  assign advance     = char_valid && char_ready;
  assign reply_ready = (state_ff == rsff_pkg::rsff_idle);

  // A4..D1 arrive in the top 12 payload bits in order A4 A2 A1 B4 ... D1
  for (genvar g = 0; g < `RSFF_AC_DIGITS; g++) begin : g_ac_digit
    // Zero pad above three code bits gives one octal digit per nibble
    assign ac_word[4*g+3 -: 4] =
      {1'b0, reply.payload[102+3*g -: 3]};             // [RULE13] [RULE14]
  end

  // Decimal digits of the field now being printed
  always_comb begin
    dec_hund = `RSFF_CHR_ZERO + dec_ff / 8'd100;
    dec_tens = `RSFF_CHR_ZERO + (dec_ff / 8'd10) % 8'd10;
    dec_unit = `RSFF_CHR_ZERO + dec_ff % 8'd10;
  end

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? `RSFF_CHR_ZERO + 8'(n)
                          : `RSFF_CHR_ALPHA + 8'(n);
  endfunction

  // Pulse edge detector; the pin idles low, so it resets low
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_prev_ff <= 1'b0;
    end else begin
      pulse_prev_ff <= pulse_per_second_input;
    end
  end

  assign pulse_edge = pulse_per_second_input && !pulse_prev_ff;

  // Free nanosecond counter restarted by each pulse edge
  always_ff @(posedge clk) begin
    if (rst || pulse_edge) begin
      since_pulse_timestamp <= 64'h0;                    // [RULE8]
    end else begin
      since_pulse_timestamp <= since_pulse_timestamp + NS_STEP;
    end
  end

  // Timestamps count as valid once a pulse edge has been seen
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_seen_ff <= 1'b0;
    end else if (pulse_edge) begin
      pulse_seen_ff <= 1'b1;                             // [RULE10]
    end
  end

  // Since-midnight counter; an external strobe marks midnight
  always_ff @(posedge clk) begin
    if (rst || midnight_clear) begin
      since_midnight_timestamp <= 64'h0;                 // [RULE9]
    end else begin
      since_midnight_timestamp <= since_midnight_timestamp + NS_STEP;
    end
  end

  assign timestamp_valid = pulse_seen_ff;                // [RULE10]

  // Field values frozen when a reply is taken, so later counts never mix in
  always_ff @(posedge clk) begin
    if (rst) begin
      ts1_ff      <= 64'h0;
      ts24_ff     <= 64'h0;
      strength_ff <= 8'h0;
      quality_ff  <= 8'h0;
    end else if (reply_valid && reply_ready) begin
      ts1_ff      <= since_pulse_timestamp;
      ts24_ff     <= since_midnight_timestamp;
      strength_ff <= reply.strength;
      quality_ff  <= reply.quality;
    end
  end

  // Character sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff    <= rsff_pkg::rsff_idle;
      shift_ff    <= 112'h0;
      count_ff    <= 5'h0;
      field_ff    <= 2'h0;
      dec_ff      <= 8'h0;
      char_data   <= 8'h0;
      char_valid  <= 1'b0;
    end else begin
      case (state_ff)
        rsff_pkg::rsff_idle: begin
          if (reply_valid) begin
            // Payload copied as received, nothing checked  [RULE3]
            case (reply.kind)
              rsff_pkg::rsff_kind_ac: begin
                shift_ff <= {ac_word, 96'h0};
                count_ff <= 5'(`RSFF_AC_DIGITS);          // [RULE12]
              end
              rsff_pkg::rsff_kind_short: begin
                shift_ff <= reply.payload;
                count_ff <= 5'(2 * `RSFF_SHORT_BYTES);    // [RULE11]
              end
              default: begin
                shift_ff <= reply.payload;
                count_ff <= 5'(2 * `RSFF_LONG_BYTES);     // [RULE11]
              end
            endcase
            char_data  <= `RSFF_CHR_STAR;                 // [RULE1]
            char_valid <= 1'b1;
            state_ff   <= rsff_pkg::rsff_head;
          end
        end

        // Star accepted: first payload digit goes out
        rsff_pkg::rsff_head: begin
          if (advance) begin
            char_data <= hex_char(shift_ff[111:108]);     // [RULE2]
            shift_ff  <= {shift_ff[107:0], 4'h0};
            count_ff  <= count_ff - 5'h1;
            state_ff  <= rsff_pkg::rsff_body;
          end
        end

        // Remaining payload digits, then semicolon and open parenthesis
        rsff_pkg::rsff_body: begin
          if (advance) begin
            if (count_ff != 5'h0) begin
              char_data <= hex_char(shift_ff[111:108]);   // [RULE2]
              shift_ff  <= {shift_ff[107:0], 4'h0};
              count_ff  <= count_ff - 5'h1;
            end else if (field_ff == 2'h0) begin
              char_data <= `RSFF_CHR_SEMI;                // [RULE1]
              field_ff  <= 2'h1;
            end else begin
              char_data <= `RSFF_CHR_LPAR;                // [RULE5]
              field_ff  <= 2'h0;
              state_ff  <= rsff_pkg::rsff_sign;
            end
          end
        end

        // Optional minus sign ahead of a decimal field
        rsff_pkg::rsff_sign: begin
          if (advance) begin
            // Strength is signed; quality is not  [RULE6] [RULE7]
            if (field_ff == 2'h0 && strength_ff[7]) begin
              char_data <= `RSFF_CHR_MINUS;
              dec_ff    <= 8'h0 - strength_ff;
              state_ff  <= rsff_pkg::rsff_dec;
            end else begin
              dec_ff    <= (field_ff == 2'h0) ? strength_ff : quality_ff;
              char_valid <= 1'b0;
              state_ff  <= rsff_pkg::rsff_dec;
            end
            count_ff <= 5'h0;
          end
        end

        // Decimal digits of strength or quality, then a comma
        rsff_pkg::rsff_dec: begin
          // Hundreds, tens, units with leading zeros suppressed
          if (advance || !char_valid) begin
            char_valid <= 1'b1;
            count_ff   <= count_ff + 5'h1;
            if (count_ff == 5'h0 && dec_ff >= 8'd100) begin
              char_data <= dec_hund;
            end else if (count_ff == 5'h1 && dec_ff >= 8'd10) begin
              char_data <= dec_tens;
            end else if (count_ff == 5'h2) begin
              char_data <= dec_unit;
            end else if (count_ff == 5'h3) begin
              char_data <= `RSFF_CHR_COMMA;               // [RULE5]
              if (field_ff == 2'h0) begin
                field_ff <= 2'h1;
                state_ff <= rsff_pkg::rsff_sign;
              end else begin
                field_ff <= 2'h2;
                shift_ff <= {ts1_ff, 48'h0} << (4 * (16 - TS1_DIGITS));
                count_ff <= 5'(TS1_DIGITS);
                state_ff <= rsff_pkg::rsff_hexf;
              end
            end else begin
              char_valid <= 1'b0;
            end
          end
        end

        // Fixed width hex timestamps, comma between, close parenthesis
        rsff_pkg::rsff_hexf: begin
          if (advance) begin
            if (count_ff != 5'h0) begin
              char_data <= hex_char(shift_ff[111:108]);   // [RULE8] [RULE9]
              shift_ff  <= {shift_ff[107:0], 4'h0};
              count_ff  <= count_ff - 5'h1;
            end else if (field_ff == 2'h2) begin
              char_data <= `RSFF_CHR_COMMA;               // [RULE5]
              field_ff  <= 2'h3;
              shift_ff  <= {ts24_ff, 48'h0} << (4 * (16 - TS24_DIGITS));
              count_ff  <= 5'(TS24_DIGITS);
            end else begin
              char_data <= `RSFF_CHR_RPAR;                // [RULE5]
              field_ff  <= 2'h0;
              count_ff  <= 5'h0;
              state_ff  <= rsff_pkg::rsff_tail;
            end
          end
        end

        // Carriage return, line feed, then back to idle
        rsff_pkg::rsff_tail: begin
          if (advance) begin
            if (count_ff == 5'h0) begin
              char_data <= `RSFF_CHR_CR;                  // [RULE5]
              count_ff  <= 5'h1;
            end else if (count_ff == 5'h1) begin
              char_data <= `RSFF_CHR_LF;
              count_ff  <= 5'h2;
            end else begin
              char_valid <= 1'b0;
              count_ff   <= 5'h0;
              state_ff   <= rsff_pkg::rsff_idle;
            end
          end
        end

        // Illegal code: drop the frame and return to idle
        default: begin
          state_ff   <= rsff_pkg::rsff_idle;
          char_valid <= 1'b0;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ### pkg/rsff_params.svh
// Purpose: Constants for the raw surveillance frame formatter
// Assumes: 10 MHz module clock
// Notes:   Included by the formatter and its package users
`ifndef RSFF_PARAMS_SVH
`define RSFF_PARAMS_SVH
`define RSFF_CHR_STAR      8'h2a
`define RSFF_CHR_SEMI      8'h3b
`define RSFF_CHR_LPAR      8'h28
`define RSFF_CHR_RPAR      8'h29
`define RSFF_CHR_COMMA     8'h2c
`define RSFF_CHR_MINUS     8'h2d
`define RSFF_CHR_CR        8'h0d
`define RSFF_CHR_LF        8'h0a
`define RSFF_CHR_ZERO      8'h30
`define RSFF_CHR_ALPHA     8'h37
`define RSFF_SHORT_BYTES   7
`define RSFF_LONG_BYTES    14
`define RSFF_AC_DIGITS     4
`define RSFF_PULSE_NS      1_000_000_000
`define RSFF_CLK_HZ        10_000_000
`define RSFF_NS_PER_CLK    (`RSFF_PULSE_NS / `RSFF_CLK_HZ)
`endif

// ### pkg/rsff_pkg.sv
// Purpose: Types for the raw surveillance frame formatter
// Assumes: Nothing
// Notes:   Reply carrier and state codes
package rsff_pkg;
  typedef enum logic [1:0] {
    rsff_kind_ac    = 2'h0,
    rsff_kind_short = 2'h1,
    rsff_kind_long  = 2'h2
  } rsff_kind_t;

  typedef struct packed {
    rsff_kind_t        kind;
    logic [111:0]      payload;
    logic signed [7:0] strength;
    logic [7:0]        quality;
  } rsff_reply_t;

  typedef enum logic [6:0] {
    rsff_idle = 7'h01,
    rsff_head = 7'h02,
    rsff_body = 7'h04,
    rsff_sign = 7'h08,
    rsff_dec  = 7'h10,
    rsff_hexf = 7'h20,
    rsff_tail = 7'h40
  } rsff_state_t;
endpackage

// ### bench/rsff_checker.sv
// Purpose: Port assertions for the raw frame formatter
// Assumes: Bound to rsff_formatter
// Notes:   One clock domain
`timescale 1ns/1ps
`default_nettype none
module rsff_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       pulse_per_second_input,
  input wire logic       reply_valid,
  input wire logic       reply_ready,
  input wire logic [7:0] char_data,
  input wire logic       char_valid,
  input wire logic       char_ready,
  input wire logic       timestamp_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take(c);
    char_valid && char_ready && char_data == c;
  endsequence
  property p_start; reply_valid && reply_ready |=>
    char_valid && char_data == 8'h2a; endproperty
  a_start: assert property (p_start) else $error("no star");
  property p_hex; s_take(8'h2a) |=> char_valid &&
    char_data inside {[8'h30:8'h39], [8'h41:8'h46]}; endproperty
  a_hex: assert property (p_hex) else $error("not hex");
  property p_hold; char_valid && !char_ready |=>
    char_valid && $stable(char_data); endproperty
  a_hold: assert property (p_hold) else $error("char lost");
  property p_busy; char_valid |-> !reply_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready in frame");
  property p_paren; s_take(8'h3b) |->
    ##[1:3] char_valid && char_data == 8'h28; endproperty
  a_paren: assert property (p_paren) else $error("no paren");
  property p_crlf; s_take(8'h0d) |=>
    char_valid && char_data == 8'h0a; endproperty
  a_crlf: assert property (p_crlf) else $error("no lf");
  property p_end; s_take(8'h0a) |=> !char_valid && reply_ready; endproperty
  a_end: assert property (p_end) else $error("no idle");
  property p_tsv; $rose(pulse_per_second_input) |->
    ##[1:3] timestamp_valid; endproperty
  a_tsv: assert property (p_tsv) else $error("ts not valid");
  property p_tsk; timestamp_valid |=> timestamp_valid; endproperty
  a_tsk: assert property (p_tsk) else $error("ts valid lost");
endmodule
bind rsff_formatter rsff_checker u_chk (.clk(clk), .rst(rst),
  .pulse_per_second_input(pulse_per_second_input),
  .reply_valid(reply_valid), .reply_ready(reply_ready),
  .char_data(char_data), .char_valid(char_valid),
  .char_ready(char_ready), .timestamp_valid(timestamp_valid));
`default_nettype wire

// ### bench/rsff_host_model.sv
// Purpose: Host sink gathering the ASCII frame stream
// Assumes: Ready changes at the falling edge only
// Notes:   Stalls half the time when slow is set
`timescale 1ns/1ps
`default_nettype none
module rsff_host_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [7:0] char_data,
  input  wire logic       char_valid,
  output var  logic       char_ready
);
  logic [1:0] cnt = 2'h0;
  byte        rx[$];
  initial char_ready = 1'b0;
  // Frames are kept raw in rx; no checking or calibration is done here
  always @(negedge clk) begin
    cnt        <= cnt + 2'h1;
    char_ready <= !slow || cnt[1];
  end
  always @(posedge clk) begin
    if (char_valid && char_ready)
      rx.push_back(char_data);
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the raw frame formatter
// Assumes: Host model sinks the character stream
// Notes:   Timestamps are judged within a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  pps = 1'b0;
  logic                  mclr = 1'b0;
  logic                  rv = 1'b0;
  logic                  slow = 1'b0;
  rsff_pkg::rsff_reply_t rp = '0;
  wire logic             rr, cv, cr, tv;
  wire logic [7:0]       cd;
  logic [63:0]           t1, t2;
  int                    num_errors = 0;
  int                    checked = 0;
  rsff_formatter dut (.clk(clk), .rst(rst), .pulse_per_second_input(pps),
    .midnight_clear(mclr), .reply_valid(rv), .reply_ready(rr), .reply(rp),
    .char_data(cd), .char_valid(cv), .char_ready(cr), .timestamp_valid(tv));
  rsff_host_model host (.clk(clk), .slow(slow), .char_data(cd),
    .char_valid(cv), .char_ready(cr));
  initial forever #50 clk = ~clk;
  task automatic check(string n, logic [63:0] s, logic [63:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %0h seen %0h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic guard(int i);
    if (i > 400) begin
      num_errors++;
      stop_test();
    end
  endtask
  function automatic byte hc(logic [3:0] n);
    return n < 4'ha ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic logic [3:0] hv(byte c);
    return c < 8'h3a ? c[3:0] : c[3:0] + 4'h9;
  endfunction
  task automatic frame(rsff_pkg::rsff_kind_t k, logic [111:0] p,
                       logic signed [7:0] s, logic [7:0] q);
    string e;
    string tl;
    int i;
    int n;
    byte c;
    logic [79:0] x;
    tl = "........,............)\015\n";
    n = k == rsff_pkg::rsff_kind_ac ? 4 :
        k == rsff_pkg::rsff_kind_short ? 14 : 28;
    e = "*";
    for (i = 0; i < n; i++)
      e = $sformatf("%s%c", e, k == rsff_pkg::rsff_kind_ac ?
          hc({1'b0, p[111-3*i -: 3]}) : hc(p[111-4*i -: 4]));
    e = $sformatf("%s;(%0d,%0d,", e, s, q);
    host.rx.delete();
    @(negedge clk);
    rp = '{k, p, s, q};
    rv = 1'b1;
    for (i = 0; !rr; i++) begin
      guard(i);
      @(negedge clk);
    end
    @(negedge clk);
    rv = 1'b0;
    for (i = 0; !(8'h0a inside {host.rx}); i++) begin
      guard(i);
      @(negedge clk);
    end
    check("len", host.rx.size(), e.len() + 24);
    for (i = 0; i < e.len(); i++)
      check("head", host.rx[i], e[i]);
    for (i = 0; i < 24; i++) begin
      c = host.rx[e.len() + i];
      if (tl[i] == ".") begin
        x = {x[75:0], hv(c)};
        check("digit", hc(hv(c)), c);
      end else
        check("sep", c, tl[i]);
    end
    t1 = x[79:48];
    t2 = x[47:0];
  endtask
  task automatic t_reset();
    check("idle", {rr, cv, tv}, 3'h4);
  endtask
  task automatic t_short();
    frame(rsff_pkg::rsff_kind_short, {56'h5d4b18fffc710b, 56'h0}, -70, 3);
  endtask
  task automatic t_long();
    slow = 1'b1;
    frame(rsff_pkg::rsff_kind_long, 112'h8d4ca7e858b9838206ba422bbd7b,
          -71, 4);
    slow = 1'b0;
  endtask
  task automatic t_squawk();
    frame(rsff_pkg::rsff_kind_ac, {12'o7700, 100'h0}, -95, 2);
    frame(rsff_pkg::rsff_kind_ac, {12'o0363, 100'h0}, 5, 0);
    frame(rsff_pkg::rsff_kind_ac, {12'o1234, 100'h0}, -128, 151);
  endtask
  task automatic t_time();
    @(negedge clk);
    pps = 1'b1;
    mclr = 1'b1;
    @(negedge clk);
    pps = 1'b0;
    mclr = 1'b0;
    repeat (40) @(negedge clk);
    frame(rsff_pkg::rsff_kind_short, {56'h0, 56'h0}, 0, 9);
    check("tsv", tv, 1'b1);
    check("ts1", t1 >= 3700 && t1 <= 4700, 1'b1);
    check("ts24", t2 >= 3700 && t2 <= 4700, 1'b1);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_short();
    t_long();
    t_squawk();
    t_time();
    stop_test();
  end
endmodule
`default_nettype wire
